//--- logic/i2c_irq_pkg.sv
// Purpose: shared constants and carriers for the i2c flag/threshold block
// Assumes: 16-bit register port, 32-entry fifos
// Notes:   offsets are byte addresses on the peripheral register port
package i2c_irq_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LVL_W  = 6;
  localparam int unsigned TL_W   = 5;

  // register map
  localparam logic [31:0] RAW_IRQ_STATUS_ADDR     = 32'h5000_1534;
  localparam logic [31:0] RECEIVE_WATERMARK_ADDR  = 32'h5000_1538;
  localparam logic [31:0] TRANSMIT_WATERMARK_ADDR = 32'h5000_153c;
  localparam logic [31:0] CLEAR_ALL_IRQS_ADDR     = 32'h5000_1540;
  localparam logic [31:0] CLEAR_RX_UNDERRUN_ADDR  = 32'h5000_1544;
  localparam logic [31:0] CLEAR_RX_OVERRUN_ADDR   = 32'h5000_1548;
  localparam logic [31:0] CLEAR_TX_OVERRUN_ADDR   = 32'h5000_154c;
  localparam logic [31:0] CLEAR_SLAVE_READ_ADDR   = 32'h5000_1550;

  // raw status bit positions
  localparam int unsigned BIT_RX_UNDER = 0;
  localparam int unsigned BIT_RX_OVER  = 1;
  localparam int unsigned BIT_RX_FULL  = 2;
  localparam int unsigned BIT_TX_OVER  = 3;
  localparam int unsigned BIT_TX_EMPTY = 4;
  localparam int unsigned BIT_RD_REQ   = 5;

  localparam logic [5:0]  FIFO_DEPTH   = 6'h20;
  localparam logic [5:0]  FIFO_EMPTY   = 6'h00;
  localparam logic [4:0]  TL_MAX       = 5'h1f;
  localparam logic [4:0]  TL_RESET     = 5'h00;
  localparam logic [15:0] DATA_ZERO    = 16'h0000;

  typedef struct packed {
    logic [5:0] rx_level;
    logic [5:0] tx_level;
  } fifo_levels_t;

  typedef struct packed {
    logic rd_req;
    logic tx_empty;
    logic tx_over;
    logic rx_full;
    logic rx_over;
    logic rx_under;
  } irq_flags_t;

endpackage

//--- logic/sync_edge.sv
// Purpose: two-flop synchroniser with any-edge detect
// Assumes: input toggles slower than two ref_clk periods
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sync_edge (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  // async level in, event out
  input  wire logic async_i,
  output logic      pulse_o
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  always_comb begin
    nxt_meta = async_i;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  assign pulse_o = sync_ff ^ last_ff;
endmodule
`default_nettype wire

//--- logic/watermark_reg.sv
// Purpose: one fifo watermark field with write clamp
// Assumes: write strobe already decoded
// Notes:   whole written word is compared so oversize values clamp
`timescale 1ns/1ps
`default_nettype none
module watermark_reg (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // write side
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  // stored field
  output logic [4:0]       level_o
);
  logic [4:0] level_ff;
  logic [4:0] nxt_level;

  always_comb begin
    nxt_level = level_ff;
    if (wr_i) begin
      if (wdata_i > {11'h000, i2c_irq_pkg::TL_MAX}) begin
        nxt_level = i2c_irq_pkg::TL_MAX;
      end else begin
        nxt_level = wdata_i[4:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      level_ff <= i2c_irq_pkg::TL_RESET;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule
`default_nettype wire

//--- logic/i2c_irq_threshold_clear.sv
// Purpose: raw flags, fifo watermarks and read-to-clear of an i2c controller
// Assumes: strobes from the controller are on ref_clk; link events toggle
// Notes:   clear registers act on the read strobe, one cycle each
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_threshold_clear (
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  // register port
  input  wire logic [31:0]               reg_addr_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic [15:0]               reg_wdata_i,
  output logic      [15:0]               reg_rdata_o,
  // controller side
  input  wire i2c_irq_pkg::fifo_levels_t fifo_levels_i,
  input  wire logic                      fifo_data_command_port_rd_i,
  input  wire logic                      fifo_data_command_port_wr_i,
  input  wire logic                      enable_bit_i,
  input  wire logic                      controller_enabled_internal_i,
  input  wire logic                      abort_cause_bit9_i,
  // link side event toggles
  input  wire logic                      rx_byte_tgl_i,
  input  wire logic                      rd_req_tgl_i,
  // status and clear outputs
  output logic      [15:0]               raw_status_o,
  output logic                           irq_combined_o,
  output logic                           clear_all_irqs_port_o,
  output logic                           clear_transmit_abort_cause_reg_o
);
  i2c_irq_pkg::irq_flags_t flags_ff;
  i2c_irq_pkg::irq_flags_t nxt_flags;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        clr_all_ff;
  logic        nxt_clr_all;
  logic        clr_abort_ff;
  logic        nxt_clr_abort;

  logic [4:0] rx_mark;
  logic [4:0] tx_tl;
  logic [5:0] tx_thresh;
  logic       rx_byte_evt;
  logic       rd_req_evt;
  logic       rx_full_cond;
  logic       tx_empty_cond;
  logic       set_rx_under;
  logic       set_rx_over;
  logic       set_tx_over;

  // register decode
  logic sel_raw;
  logic sel_rx_mark;
  logic sel_tx_tl;
  logic clear_all_irqs_port;
  logic receive_underrun_clear_port;
  logic receive_overrun_clear_port;
  logic transmit_overrun_clear_port;
  logic slave_read_clear_port;

  assign sel_raw   = reg_addr_i == i2c_irq_pkg::RAW_IRQ_STATUS_ADDR;
  assign sel_rx_mark = reg_addr_i == i2c_irq_pkg::RECEIVE_WATERMARK_ADDR;
  assign sel_tx_tl = reg_addr_i == i2c_irq_pkg::TRANSMIT_WATERMARK_ADDR;
  assign clear_all_irqs_port = reg_rd_i &&
    (reg_addr_i == i2c_irq_pkg::CLEAR_ALL_IRQS_ADDR);
  assign receive_underrun_clear_port = reg_rd_i &&
    (reg_addr_i == i2c_irq_pkg::CLEAR_RX_UNDERRUN_ADDR);
  assign receive_overrun_clear_port = reg_rd_i &&
    (reg_addr_i == i2c_irq_pkg::CLEAR_RX_OVERRUN_ADDR);
  assign transmit_overrun_clear_port = reg_rd_i &&
    (reg_addr_i == i2c_irq_pkg::CLEAR_TX_OVERRUN_ADDR);
  assign slave_read_clear_port = reg_rd_i &&
    (reg_addr_i == i2c_irq_pkg::CLEAR_SLAVE_READ_ADDR);

  // watermark fields
  watermark_reg u_rx_mark (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (reg_wr_i && sel_rx_mark),
    .wdata_i   (reg_wdata_i),
    .level_o   (rx_mark)
  );

  watermark_reg u_tx_tl (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_i      (reg_wr_i && sel_tx_tl),
    .wdata_i   (reg_wdata_i),
    .level_o   (tx_tl)
  );

  // link events cross by toggle, two flops before use
  sync_edge u_rx_byte (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (rx_byte_tgl_i),
    .pulse_o   (rx_byte_evt)
  );

  sync_edge u_rd_req (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (rd_req_tgl_i),
    .pulse_o   (rd_req_evt)
  );

  // 31 stands for the full fifo so a full-fifo threshold is reachable
  assign tx_thresh = (tx_tl == i2c_irq_pkg::TL_MAX) ?
    i2c_irq_pkg::FIFO_DEPTH : {1'b0, tx_tl};
  assign rx_full_cond = enable_bit_i &&
    (fifo_levels_i.rx_level > {1'b0, rx_mark});
  // disabled fifo looks empty until the controller drops its enable
  assign tx_empty_cond = enable_bit_i ?
    (fifo_levels_i.tx_level <= tx_thresh) :
    controller_enabled_internal_i;
  assign set_rx_under = fifo_data_command_port_rd_i &&
    (fifo_levels_i.rx_level == i2c_irq_pkg::FIFO_EMPTY);
  assign set_rx_over = rx_byte_evt &&
    (fifo_levels_i.rx_level == i2c_irq_pkg::FIFO_DEPTH);
  assign set_tx_over = fifo_data_command_port_wr_i &&
    (fifo_levels_i.tx_level == i2c_irq_pkg::FIFO_DEPTH);

  // flag update: a set always beats a clear in the same cycle
  always_comb begin
    nxt_flags = flags_ff;
    nxt_flags.rx_under = set_rx_under || (flags_ff.rx_under &&
      !receive_underrun_clear_port && !clear_all_irqs_port &&
      controller_enabled_internal_i);
    nxt_flags.rx_over = set_rx_over || (flags_ff.rx_over &&
      !receive_overrun_clear_port && !clear_all_irqs_port &&
      controller_enabled_internal_i);
    nxt_flags.tx_over = set_tx_over || (flags_ff.tx_over &&
      !transmit_overrun_clear_port && !clear_all_irqs_port &&
      controller_enabled_internal_i);
    nxt_flags.rd_req = rd_req_evt || (flags_ff.rd_req &&
      !slave_read_clear_port && !clear_all_irqs_port);
    // watermark flags follow levels and enables only, never the clear reads
    nxt_flags.rx_full  = rx_full_cond;
    nxt_flags.tx_empty = tx_empty_cond;
  end

  // read data: clear registers return the flag as it stood before the read
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      nxt_rdata = i2c_irq_pkg::DATA_ZERO;
      if (sel_raw) begin
        nxt_rdata = raw_status_o;
      end else if (sel_rx_mark) begin
        nxt_rdata = {11'h000, rx_mark};
      end else if (sel_tx_tl) begin
        nxt_rdata = {11'h000, tx_tl};
      end else if (clear_all_irqs_port) begin
        nxt_rdata = {15'h0000, irq_combined_o};
      end else if (receive_underrun_clear_port) begin
        nxt_rdata = {15'h0000, flags_ff.rx_under};
      end else if (receive_overrun_clear_port) begin
        nxt_rdata = {15'h0000, flags_ff.rx_over};
      end else if (transmit_overrun_clear_port) begin
        nxt_rdata = {15'h0000, flags_ff.tx_over};
      end else if (slave_read_clear_port) begin
        nxt_rdata = {15'h0000, flags_ff.rd_req};
      end
    end
  end

  always_comb begin
    nxt_clr_all   = clear_all_irqs_port;
    nxt_clr_abort = clear_all_irqs_port && !abort_cause_bit9_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      flags_ff     <= '0;
      rdata_ff     <= i2c_irq_pkg::DATA_ZERO;
      clr_all_ff   <= 1'b0;
      clr_abort_ff <= 1'b0;
    end else begin
      flags_ff     <= nxt_flags;
      rdata_ff     <= nxt_rdata;
      clr_all_ff   <= nxt_clr_all;
      clr_abort_ff <= nxt_clr_abort;
    end
  end

  always_comb begin
    raw_status_o = i2c_irq_pkg::DATA_ZERO;
    raw_status_o[i2c_irq_pkg::BIT_RX_UNDER] = flags_ff.rx_under;
    raw_status_o[i2c_irq_pkg::BIT_RX_OVER]  = flags_ff.rx_over;
    raw_status_o[i2c_irq_pkg::BIT_RX_FULL]  = flags_ff.rx_full;
    raw_status_o[i2c_irq_pkg::BIT_TX_OVER]  = flags_ff.tx_over;
    raw_status_o[i2c_irq_pkg::BIT_TX_EMPTY] = flags_ff.tx_empty;
    raw_status_o[i2c_irq_pkg::BIT_RD_REQ]   = flags_ff.rd_req;
  end

  assign irq_combined_o                   = |flags_ff;
  assign reg_rdata_o                      = rdata_ff;
  assign clear_all_irqs_port_o            = clr_all_ff;
  assign clear_transmit_abort_cause_reg_o = clr_abort_ff;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_rx_under_set;
    set_rx_under |=> flags_ff.rx_under;
  endproperty
  a_rx_under_set: assert property (p_rx_under_set)
    else $error("underrun not set on empty read");

  property p_rx_under_hold;
    flags_ff.rx_under && controller_enabled_internal_i && !enable_bit_i &&
      !receive_underrun_clear_port && !clear_all_irqs_port
      |=> flags_ff.rx_under;
  endproperty
  a_rx_under_hold: assert property (p_rx_under_hold)
    else $error("underrun lost while disabling");

  property p_rx_under_drop;
    !controller_enabled_internal_i && !set_rx_under |=> !flags_ff.rx_under;
  endproperty
  a_rx_under_drop: assert property (p_rx_under_drop)
    else $error("underrun kept after enable fell");

  property p_rx_full;
    enable_bit_i |=> flags_ff.rx_full ==
      ($past(fifo_levels_i.rx_level) >= $past(rx_mark) + 6'h01);
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("receive watermark flag wrong");

  property p_rx_mark_clamp;
    reg_wr_i && sel_rx_mark && reg_wdata_i > 16'h001f |=> rx_mark == 5'h1f;
  endproperty
  a_rx_mark_clamp: assert property (p_rx_mark_clamp)
    else $error("receive watermark not clamped");

  property p_tx_tl_clamp;
    reg_wr_i && sel_tx_tl && reg_wdata_i > 16'h001f |=> tx_tl == 5'h1f;
  endproperty
  a_tx_tl_clamp: assert property (p_tx_tl_clamp)
    else $error("transmit watermark not clamped");

  property p_tx_low_set;
    enable_bit_i && tx_tl == 5'h1f && fifo_levels_i.tx_level == 6'h20
      |=> flags_ff.tx_empty;
  endproperty
  a_tx_low_set: assert property (p_tx_low_set)
    else $error("low-water flag missing at 32 entries");

  property p_tx_low_clear;
    enable_bit_i && fifo_levels_i.tx_level > tx_thresh |=> !flags_ff.tx_empty;
  endproperty
  a_tx_low_clear: assert property (p_tx_low_clear)
    else $error("low-water flag stuck above threshold");

  property p_clear_all;
    clear_all_irqs_port && !set_rx_under && !set_rx_over && !set_tx_over &&
      !rd_req_evt |=> !flags_ff.rx_under && !flags_ff.rx_over &&
      !flags_ff.tx_over && !flags_ff.rd_req && clear_all_irqs_port_o;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("global clear left a soft flag");

  property p_clear_all_hw;
    clear_all_irqs_port && enable_bit_i && rx_full_cond |=> flags_ff.rx_full;
  endproperty
  a_clear_all_hw: assert property (p_clear_all_hw)
    else $error("global clear touched watermark flag");

  property p_abort_exception;
    clear_all_irqs_port |=>
      clear_transmit_abort_cause_reg_o == !$past(abort_cause_bit9_i);
  endproperty
  a_abort_exception: assert property (p_abort_exception)
    else $error("abort cause clear ignores bit 9");

  property p_clr_under;
    receive_underrun_clear_port && !set_rx_under |=> !flags_ff.rx_under;
  endproperty
  a_clr_under: assert property (p_clr_under)
    else $error("underrun clear failed");

  property p_clr_over;
    receive_overrun_clear_port && !set_rx_over |=> !flags_ff.rx_over;
  endproperty
  a_clr_over: assert property (p_clr_over)
    else $error("receive overrun clear failed");

  property p_transmit_overrun_clear_port;
    transmit_overrun_clear_port && !set_tx_over |=> !flags_ff.tx_over;
  endproperty
  a_transmit_overrun_clear_port: assert property (p_transmit_overrun_clear_port)
    else $error("transmit overrun clear failed");

  property p_slave_read_clear_port;
    slave_read_clear_port && !rd_req_evt |=> !flags_ff.rd_req;
  endproperty
  a_slave_read_clear_port: assert property (p_slave_read_clear_port)
    else $error("slave read clear failed");

  property p_tx_over_set;
    set_tx_over |=> flags_ff.tx_over ##0 raw_status_o[3];
  endproperty
  a_tx_over_set: assert property (p_tx_over_set)
    else $error("transmit overrun not set at 32");

  property p_idle_clear;
    receive_overrun_clear_port && !flags_ff.rx_over && !set_rx_over
      |=> !flags_ff.rx_over && reg_rdata_o == 16'h0000;
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("clear of idle flag had an effect");

  c_underrun: cover property (set_rx_under ##1 receive_underrun_clear_port);
  c_global:   cover property (flags_ff.rd_req ##1 clear_all_irqs_port);
  c_tx_low:   cover property (flags_ff.tx_empty ##1 !flags_ff.tx_empty);
  c_clamp:    cover property (reg_wr_i && sel_rx_mark && reg_wdata_i[5]);
endmodule
`default_nettype wire

//--- tb/link_partner.sv
// Purpose: far side model, bus events seen by the flag logic
// Assumes: one event toggle per link period of 48 ns
// Notes:   toggles idle between events, never pulse back
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  // event toggles toward the block
  output logic rx_byte_tgl_o,
  output logic rd_req_tgl_o
);
  initial begin
    rx_byte_tgl_o = 1'b0;
    rd_req_tgl_o  = 1'b0;
  end
  // a received byte lands one link period after the request
  task automatic byte_in();
    #48 rx_byte_tgl_o = ~rx_byte_tgl_o;
  endtask
  // remote master addresses us for a read
  task automatic read_req();
    #48 rd_req_tgl_o = ~rd_req_tgl_o;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_i2c_irq_threshold_clear.sv
// Purpose: register level tests of flags, watermarks and clear reads
// Assumes: read data and flags visible one cycle after their cause
// Notes:   levels and data port strobes driven here, link by partner
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_irq_threshold_clear;
  logic                      ref_clk_i = 1'b0;
  logic                      reset_n_i = 1'b0;
  logic [31:0]               a_q = 32'h0000_0000;
  logic                      wr_q = 1'b0;
  logic                      rd_q = 1'b0;
  logic [15:0]               wd_q = 16'h0000;
  i2c_irq_pkg::fifo_levels_t lv = '0;
  logic                      dp_rd = 1'b0;
  logic                      dp_wr = 1'b0;
  logic                      en = 1'b1;
  logic                      en_int = 1'b1;
  logic                      b9 = 1'b0;
  logic                      rx_t;
  logic                      rq_t;
  logic [15:0]               rdata;
  logic [15:0]               raw;
  logic                      irq_c;
  logic                      clr_all;
  logic                      clr_abt;
  logic [15:0]               d;
  int                        fails = 0;
  int                        compares = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  i2c_irq_threshold_clear dut (
    .ref_clk_i                        (ref_clk_i),
    .reset_n_i                        (reset_n_i),
    .reg_addr_i                       (a_q),
    .reg_wr_i                         (wr_q),
    .reg_rd_i                         (rd_q),
    .reg_wdata_i                      (wd_q),
    .reg_rdata_o                      (rdata),
    .fifo_levels_i                    (lv),
    .fifo_data_command_port_rd_i      (dp_rd),
    .fifo_data_command_port_wr_i      (dp_wr),
    .enable_bit_i                     (en),
    .controller_enabled_internal_i    (en_int),
    .abort_cause_bit9_i               (b9),
    .rx_byte_tgl_i                    (rx_t),
    .rd_req_tgl_i                     (rq_t),
    .raw_status_o                     (raw),
    .irq_combined_o                   (irq_c),
    .clear_all_irqs_port_o            (clr_all),
    .clear_transmit_abort_cause_reg_o (clr_abt)
  );

  link_partner far (
    .rx_byte_tgl_o (rx_t),
    .rd_req_tgl_o  (rq_t)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bit_chk(input int n, input logic v);
    chk({15'h0000, raw[n]}, {15'h0000, v});
  endtask

  // result sampled after the edge that registered it
  task automatic rd(input logic [31:0] a, output logic [15:0] q);
    @(posedge ref_clk_i);
    a_q  <= a;
    rd_q <= 1'b1;
    @(posedge ref_clk_i);
    rd_q <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    a_q  <= a;
    wd_q <= v;
    wr_q <= 1'b1;
    @(posedge ref_clk_i);
    wr_q <= 1'b0;
  endtask

  task automatic set_lv(input logic [5:0] r, input logic [5:0] t);
    @(posedge ref_clk_i);
    lv.rx_level <= r;
    lv.tx_level <= t;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic dp(input logic is_rd);
    @(posedge ref_clk_i);
    if (is_rd) dp_rd <= 1'b1;
    else dp_wr <= 1'b1;
    @(posedge ref_clk_i);
    dp_rd <= 1'b0;
    dp_wr <= 1'b0;
    #1;
  endtask

  // link events pass a synchroniser: bounded wait on the flag
  task automatic wait_bit(input int n);
    for (int i = 0; i < 10 && raw[n] !== 1'b1; i++) @(posedge ref_clk_i);
    #1 bit_chk(n, 1'b1);
  endtask

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    complete_run();
  end

  initial begin
    lv.tx_level = 6'h08;
    repeat (8) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    // all eight registers, then one unmapped place
    for (int i = 0; i < 9; i++) begin
      rd(32'h5000_1534 + 32'(i * 4), d);
      chk(d, 16'h0000);
    end
    wr(32'h5000_1554, 16'h0007);
    rd(i2c_irq_pkg::TRANSMIT_WATERMARK_ADDR, d);
    chk(d, 16'h0000);
    wr(i2c_irq_pkg::RECEIVE_WATERMARK_ADDR, 16'h0040);
    rd(i2c_irq_pkg::RECEIVE_WATERMARK_ADDR, d);
    chk(d, 16'h001f);
    wr(i2c_irq_pkg::RECEIVE_WATERMARK_ADDR, 16'h0005);
    rd(i2c_irq_pkg::RECEIVE_WATERMARK_ADDR, d);
    chk(d, 16'h0005);
    set_lv(6'h05, 6'h08);
    bit_chk(2, 1'b0);
    set_lv(6'h06, 6'h08);
    bit_chk(2, 1'b1);
    set_lv(6'h00, 6'h08);
    bit_chk(2, 1'b0);
    wr(i2c_irq_pkg::TRANSMIT_WATERMARK_ADDR, 16'hffff);
    rd(i2c_irq_pkg::TRANSMIT_WATERMARK_ADDR, d);
    chk(d, 16'h001f);
    set_lv(6'h00, 6'h20);
    bit_chk(4, 1'b1);
    wr(i2c_irq_pkg::TRANSMIT_WATERMARK_ADDR, 16'h0003);
    set_lv(6'h00, 6'h03);
    bit_chk(4, 1'b1);
    set_lv(6'h00, 6'h04);
    bit_chk(4, 1'b0);
    dp(1'b1);
    bit_chk(0, 1'b1);
    rd(i2c_irq_pkg::CLEAR_RX_UNDERRUN_ADDR, d);
    chk(d, 16'h0001);
    bit_chk(0, 1'b0);
    rd(i2c_irq_pkg::CLEAR_RX_UNDERRUN_ADDR, d);
    chk(d, 16'h0000);
    set_lv(6'h00, 6'h1f);
    dp(1'b0);
    bit_chk(3, 1'b0);
    set_lv(6'h00, 6'h20);
    dp(1'b0);
    bit_chk(3, 1'b1);
    rd(i2c_irq_pkg::CLEAR_TX_OVERRUN_ADDR, d);
    chk(d, 16'h0001);
    bit_chk(3, 1'b0);
    set_lv(6'h20, 6'h08);
    far.byte_in();
    wait_bit(1);
    rd(i2c_irq_pkg::CLEAR_RX_OVERRUN_ADDR, d);
    chk(d, 16'h0001);
    bit_chk(1, 1'b0);
    far.read_req();
    wait_bit(5);
    rd(i2c_irq_pkg::CLEAR_SLAVE_READ_ADDR, d);
    chk(d, 16'h0001);
    bit_chk(5, 1'b0);
    // global clear twice: abort cause cleared, then kept by bit 9
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_i);
      b9 <= k[0];
      set_lv(6'h00, 6'h08);
      dp(1'b1);
      far.read_req();
      wait_bit(5);
      set_lv(6'h06, 6'h08);
      rd(i2c_irq_pkg::CLEAR_ALL_IRQS_ADDR, d);
      chk(d, 16'h0001);
      chk({15'h0000, clr_all}, 16'h0001);
      chk({15'h0000, clr_abt}, {15'h0000, ~k[0]});
      chk(raw, 16'h0004);
      chk({15'h0000, irq_c}, 16'h0001);
      @(posedge ref_clk_i);
      #1 chk({14'h0000, clr_all, clr_abt}, 16'h0000);
    end
    @(posedge ref_clk_i);
    b9 <= 1'b0;
    set_lv(6'h00, 6'h08);
    dp(1'b1);
    @(posedge ref_clk_i);
    en <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 bit_chk(0, 1'b1);
    bit_chk(4, 1'b1);
    @(posedge ref_clk_i);
    en_int <= 1'b0;
    @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    #1 bit_chk(0, 1'b0);
    chk({15'h0000, irq_c}, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
